// ===== shared/ihac_regs.svh
`ifndef IHAC_REGS_SVH
`define IHAC_REGS_SVH

// Register port offsets (byte addresses on the register port)
`define IHAC_OFS_AUX_MODE     5'h0_00B
`define IHAC_OFS_PRIM_ADDR    5'h0_00D
`define IHAC_OFS_CAPTURE      5'h0_001

// Control code field of an aux mode port write
`define IHAC_CNT_HI           7
`define IHAC_CNT_LO           5
`define IHAC_CNT_AUX_CMD      3'h0
`define IHAC_CNT_OPTIONS      3'h5
`define IHAC_CNT_HOLDOFF      3'h6

// Auxiliary command codes carried in the command code field
`define IHAC_COM_VALID        5'h0_00F
`define IHAC_COM_FINISH       5'h0_003

// Interface options bit positions
`define IHAC_OPT_SRC_FAST     2
`define IHAC_OPT_SP_END       1
`define IHAC_OPT_PASS_EN      0

// Holdoff configuration bit positions
`define IHAC_HLD_ON_CLEAR     1
`define IHAC_HLD_ON_TRIGGER   0

// Primary address write select bit
`define IHAC_ADR_SELECT       7

// Reset values
`define IHAC_OPTIONS_RST      5'h0_000
`define IHAC_HOLDOFF_RST      2'h0
`define IHAC_PRIM_ADDR_RST    7'h0_000

// Address group offsets (octal 100 and octal 40)
`define IHAC_TALK_GROUP       2'h2
`define IHAC_LISTEN_GROUP     2'h1

// First code of the address and secondary command groups
`define IHAC_ADDR_GROUP_BASE  7'h0_020

// Defined universal and addressed command codes
`define IHAC_CMD_GTL          7'h0_001
`define IHAC_CMD_SDC          7'h0_004
`define IHAC_CMD_PPC          7'h0_005
`define IHAC_CMD_GET          7'h0_008
`define IHAC_CMD_TCT          7'h0_009
`define IHAC_CMD_LLO          7'h0_011
`define IHAC_CMD_DCL          7'h0_014
`define IHAC_CMD_PPU          7'h0_015
`define IHAC_CMD_SPE          7'h0_018
`define IHAC_CMD_SPD          7'h0_019

// Source handshake settling times and clock period
`define IHAC_CLK_PERIOD_NS    5
`define IHAC_T1_SLOW_NS       2000
`define IHAC_T1_FAST_NS       500
`define IHAC_T1_SLOW_CYC \
   ((`IHAC_T1_SLOW_NS + `IHAC_CLK_PERIOD_NS - 1) / `IHAC_CLK_PERIOD_NS)
`define IHAC_T1_FAST_CYC \
   ((`IHAC_T1_FAST_NS + `IHAC_CLK_PERIOD_NS - 1) / `IHAC_CLK_PERIOD_NS)

`endif

// ===== shared/ihac_pkg.sv
`default_nettype none

package ihac_pkg;

   typedef struct packed {
      logic [1:0] upper;
      logic       srcFast;
      logic       spEnd;
      logic       passEn;
   } ihac_options_t;

   typedef struct packed {
      logic holdClr;
      logic holdTrig;
   } ihac_holdoff_t;

   typedef struct packed {
      logic       talkDis;
      logic       listenDis;
      logic [4:0] addr;
   } ihac_prim_addr_t;

   typedef enum logic {
      SRC_IDLE,
      SRC_SETTLE
   } ihac_src_state_t;

endpackage

`default_nettype wire

// ===== rtl/ihac_addr_match.sv
`include "ihac_regs.svh"
`default_nettype none

module ihac_addr_match
   import ihac_pkg::*;
(
   // Clock and reset
   input  wire logic            clk_sys,
   input  wire logic            rst,
   // Received command byte
   input  wire logic            cmdValid,
   input  wire logic [7:0]      cmdByte,
   // Primary address in use
   input  wire ihac_prim_addr_t primAddr,
   // Match pulses
   output var  logic            talkMatch_r,
   output var  logic            listenMatch_r
);

   logic isTalk;
   logic isListen;

   // Parity bit 7 is not part of the address
   assign isTalk   = cmdByte[6:0] == {`IHAC_TALK_GROUP, primAddr.addr};
   assign isListen = cmdByte[6:0] == {`IHAC_LISTEN_GROUP, primAddr.addr};

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         talkMatch_r   <= 1'b0;
         listenMatch_r <= 1'b0;
      end else begin
         talkMatch_r   <= cmdValid && isTalk && !primAddr.talkDis;
         listenMatch_r <= cmdValid && isListen && !primAddr.listenDis;
      end
   end

   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (rst);

   property p_talk_match;
      cmdValid && cmdByte[6:5] == 2'h2 && cmdByte[4:0] == primAddr.addr
         |=> talkMatch_r == !$past(primAddr.talkDis);
   endproperty
   a_talk_match: assert property (p_talk_match)
      else $error("Talk address match wrong");

   property p_listen_match;
      cmdValid && cmdByte[6:5] == 2'h1 && cmdByte[4:0] == primAddr.addr
         |=> listenMatch_r == !$past(primAddr.listenDis);
   endproperty
   a_listen_match: assert property (p_listen_match)
      else $error("Listen address match wrong");

   property p_no_stray_match;
      !cmdValid |=> !talkMatch_r && !listenMatch_r;
   endproperty
   a_no_stray_match: assert property (p_no_stray_match)
      else $error("Address match without a command byte");

endmodule

`default_nettype wire

// ===== rtl/ihac_ctl.sv
`include "ihac_regs.svh"
`default_nettype none
// Overview of operation
// - Fast source settling after first byte
// - Slow settling on every byte when clear
// - Open-collector drive only during parallel poll
// - Serial poll EOI follows serial poll end bit
// - Pass enable gates unknown command detection
// - Unknown command holds DAC until Valid
// - Unknown command byte captured for software
// - Aux code 110 loads holdoff bits
// - Hold DAC on entering device clear
// - Hold DAC on entering device trigger
// - Finish handshake releases clear/trigger holdoff
// - Primary address readback is read-only
// - Readback shows the primary address only
// - Talk disable ignores matching talk address
// - Listen disable ignores matching listen address
// - Talk plus octal 100, listen octal 40
// - Aux code 101 loads interface options

module ihac_ctl
   import ihac_pkg::*;
#(
   parameter int SLOW_CYC = `IHAC_T1_SLOW_CYC,
   parameter int FAST_CYC = `IHAC_T1_FAST_CYC
) (
   // Clock and reset
   input  wire logic       clk_sys,
   input  wire logic       rst,
   // Register port
   input  wire logic       regWrEn,
   input  wire logic       regRdEn,
   input  wire logic [4:0] regAddr,
   input  wire logic [7:0] regWrData,
   output var  logic [7:0] regRdData_r,
   // Core states
   input  wire logic       spasActive,
   input  wire logic       dcasActive,
   input  wire logic       dtasActive,
   input  wire logic       pollResponse,
   input  wire logic       talkEoiReq,
   // Received command bytes
   input  wire logic       cmdValid,
   input  wire logic [7:0] cmdByte,
   // Source handshake
   input  wire logic       srcTalkActive,
   input  wire logic       srcStart,
   output var  logic       srcSettled_r,
   // Bus side results
   output var  logic       eoiAssert_r,
   output var  logic       driveOpenCollector_r,
   output var  logic       dacHoldoff_r,
   output var  logic       unknownCmdFlag_r,
   output var  logic       talkAddrMatch_r,
   output var  logic       listenAddrMatch_r
);

   localparam int CntW = 16;

   function automatic logic isDefinedCmd(input logic [7:0] b);
      logic [6:0] c;
      c = b[6:0];
      if (c >= `IHAC_ADDR_GROUP_BASE) begin
         return 1'b1;
      end
      case (c)
         `IHAC_CMD_GTL, `IHAC_CMD_SDC, `IHAC_CMD_PPC, `IHAC_CMD_GET,
         `IHAC_CMD_TCT, `IHAC_CMD_LLO, `IHAC_CMD_DCL, `IHAC_CMD_PPU,
         `IHAC_CMD_SPE, `IHAC_CMD_SPD: return 1'b1;
         default: return 1'b0;
      endcase
   endfunction

   function automatic logic [CntW-1:0] toCnt(input int n);
      return CntW'(n);
   endfunction

   ihac_options_t   options_r;
   ihac_holdoff_t   holdCfg_r;
   ihac_prim_addr_t primAddr_r;
   logic [7:0]      capture_r;

   logic auxWr;
   logic [2:0] ctlCode;
   logic [4:0] comCode;
   logic validCmd;
   logic finishCmd;
   logic unknownHit;

   assign auxWr     = regWrEn && regAddr == `IHAC_OFS_AUX_MODE;
   assign ctlCode   = regWrData[`IHAC_CNT_HI:`IHAC_CNT_LO];
   assign comCode   = regWrData[4:0];
   assign validCmd  = auxWr && ctlCode == `IHAC_CNT_AUX_CMD
                      && comCode == `IHAC_COM_VALID;
   assign finishCmd = auxWr && ctlCode == `IHAC_CNT_AUX_CMD
                      && comCode == `IHAC_COM_FINISH;
   assign unknownHit = cmdValid && options_r.passEn
                       && !isDefinedCmd(cmdByte);

   // Option and holdoff registers, written only through the aux mode port
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         options_r <= `IHAC_OPTIONS_RST;
         holdCfg_r <= `IHAC_HOLDOFF_RST;
      end else if (auxWr) begin
         if (ctlCode == `IHAC_CNT_OPTIONS) begin
            options_r <= comCode;
         end
         if (ctlCode == `IHAC_CNT_HOLDOFF) begin
            // Bits 4-2 are expected zero and are dropped
            holdCfg_r <= comCode[1:0];
         end
      end
   end

   // Primary address: bit 7 clear selects the primary slot
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         primAddr_r <= `IHAC_PRIM_ADDR_RST;
      end else if (regWrEn && regAddr == `IHAC_OFS_PRIM_ADDR
                   && !regWrData[`IHAC_ADR_SELECT]) begin
         primAddr_r <= regWrData[6:0];
      end
   end

   // Register reads, one cycle after the strobe
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         regRdData_r <= 8'h00;
      end else if (regRdEn) begin
         case (regAddr)
            // Bit 7 driven zero; software must not rely on it
            `IHAC_OFS_PRIM_ADDR: regRdData_r <= {1'b0, primAddr_r};
            `IHAC_OFS_CAPTURE:   regRdData_r <= capture_r;
            default:             regRdData_r <= 8'h00;
         endcase
      end
   end

   // Unknown command capture and flag
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         capture_r        <= 8'h00;
         unknownCmdFlag_r <= 1'b0;
      end else begin
         unknownCmdFlag_r <= unknownHit;
         if (unknownHit) begin
            capture_r <= cmdByte;
         end
      end
   end

   // DAC holdoffs; a new cause in the release cycle wins
   logic passHold_r;
   logic clrHold_r;
   logic trigHold_r;
   logic dcasPrev_r;
   logic dtasPrev_r;
   logic passHoldNxt;
   logic clrHoldNxt;
   logic trigHoldNxt;
   logic clrEntry;
   logic trigEntry;

   assign clrEntry    = dcasActive && !dcasPrev_r && holdCfg_r.holdClr;
   assign trigEntry   = dtasActive && !dtasPrev_r && holdCfg_r.holdTrig;
   assign passHoldNxt = unknownHit || (passHold_r && !validCmd);
   assign clrHoldNxt  = clrEntry || (clrHold_r && !finishCmd);
   assign trigHoldNxt = trigEntry || (trigHold_r && !finishCmd);

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         dcasPrev_r   <= 1'b0;
         dtasPrev_r   <= 1'b0;
         passHold_r   <= 1'b0;
         clrHold_r    <= 1'b0;
         trigHold_r   <= 1'b0;
         dacHoldoff_r <= 1'b0;
      end else begin
         dcasPrev_r   <= dcasActive;
         dtasPrev_r   <= dtasActive;
         passHold_r   <= passHoldNxt;
         clrHold_r    <= clrHoldNxt;
         trigHold_r   <= trigHoldNxt;
         dacHoldoff_r <= passHoldNxt || clrHoldNxt || trigHoldNxt;
      end
   end

   // EOI and driver mode
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         eoiAssert_r          <= 1'b0;
         driveOpenCollector_r <= 1'b0;
      end else begin
         eoiAssert_r <= spasActive ? options_r.spEnd : talkEoiReq;
         driveOpenCollector_r <= pollResponse;
      end
   end

   // Source handshake settling timer
   ihac_src_state_t srcState_r;
   logic [CntW-1:0] settleCnt_r;
   logic            firstByte_r;
   logic            useFast_r;
   logic            startOk;

   assign startOk = srcStart && srcState_r == SRC_IDLE;

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         firstByte_r <= 1'b1;
      end else if (!srcTalkActive) begin
         firstByte_r <= 1'b1;
      end else if (startOk) begin
         firstByte_r <= 1'b0;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         srcState_r   <= SRC_IDLE;
         settleCnt_r  <= '0;
         useFast_r    <= 1'b0;
         srcSettled_r <= 1'b0;
      end else begin
         srcSettled_r <= 1'b0;
         case (srcState_r)
            SRC_IDLE: begin
               if (startOk) begin
                  // Fast only once the first byte has gone out
                  useFast_r  <= options_r.srcFast && !firstByte_r;
                  settleCnt_r <= (options_r.srcFast && !firstByte_r)
                                 ? toCnt(FAST_CYC - 1)
                                 : toCnt(SLOW_CYC - 1);
                  srcState_r <= SRC_SETTLE;
               end
            end
            SRC_SETTLE: begin
               if (settleCnt_r == '0) begin
                  srcSettled_r <= 1'b1;
                  srcState_r   <= SRC_IDLE;
               end else begin
                  settleCnt_r <= settleCnt_r - 1'b1;
               end
            end
            default: srcState_r <= SRC_IDLE;
         endcase
      end
   end

   ihac_addr_match u_addr_match (
      .clk_sys       (clk_sys),
      .rst           (rst),
      .cmdValid      (cmdValid),
      .cmdByte       (cmdByte),
      .primAddr      (primAddr_r),
      .talkMatch_r   (talkAddrMatch_r),
      .listenMatch_r (listenAddrMatch_r)
   );

   // Helper: cycles spent settling, for the timing checks
   logic [CntW-1:0] chkCnt_r;
   always_ff @(posedge clk_sys) begin
      if (rst || startOk) begin
         chkCnt_r <= '0;
      end else if (srcState_r == SRC_SETTLE) begin
         chkCnt_r <= chkCnt_r + 1'b1;
      end
   end

   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (rst);

   property p_fast_timing;
      srcSettled_r && useFast_r |-> chkCnt_r == toCnt(FAST_CYC);
   endproperty
   a_fast_timing: assert property (p_fast_timing)
      else $error("Fast settling count wrong");

   property p_slow_timing;
      srcSettled_r && !useFast_r |-> chkCnt_r == toCnt(SLOW_CYC);
   endproperty
   a_slow_timing: assert property (p_slow_timing)
      else $error("Slow settling count wrong");

   property p_first_slow;
      startOk && (firstByte_r || !options_r.srcFast) |=> !useFast_r;
   endproperty
   a_first_slow: assert property (p_first_slow)
      else $error("Fast timing used on first byte or when disabled");

   property p_oc_drive;
      pollResponse[*2] |=> driveOpenCollector_r;
   endproperty
   a_oc_drive: assert property (p_oc_drive)
      else $error("Drivers not open collector in poll response");

   property p_serial_poll_active_state_eoi;
      spasActive |=> eoiAssert_r == $past(options_r.spEnd);
   endproperty
   a_serial_poll_active_state_eoi: assert property (p_serial_poll_active_state_eoi)
      else $error("Serial poll EOI does not follow option");

   property p_no_pass;
      !options_r.passEn |=> !unknownCmdFlag_r;
   endproperty
   a_no_pass: assert property (p_no_pass)
      else $error("Unknown command flagged while pass disabled");

   property p_pass_hold;
      passHold_r && !validCmd
         |=> passHold_r && dacHoldoff_r;
   endproperty
   a_pass_hold: assert property (p_pass_hold)
      else $error("DAC not held after unknown command");

   property p_capture;
      unknownHit |=> capture_r == $past(cmdByte) && unknownCmdFlag_r;
   endproperty
   a_capture: assert property (p_capture)
      else $error("Unknown command byte not captured");

   property p_holdoff_load;
      auxWr && ctlCode == `IHAC_CNT_HOLDOFF
         |=> holdCfg_r == $past(regWrData[1:0]);
   endproperty
   a_holdoff_load: assert property (p_holdoff_load)
      else $error("Holdoff configuration not loaded");

   property p_clear_hold;
      dcasActive && !dcasPrev_r && !clrHold_r |=> (!clrHold_r || dacHoldoff_r)
         && clrHold_r == $past(holdCfg_r.holdClr);
   endproperty
   a_clear_hold: assert property (p_clear_hold)
      else $error("Device clear holdoff wrong");

   property p_trig_hold;
      $rose(dtasActive) && holdCfg_r.holdTrig |=> dacHoldoff_r && trigHold_r;
   endproperty
   a_trig_hold: assert property (p_trig_hold)
      else $error("Device trigger holdoff missing");

   property p_finish_only;
      (clrHold_r || trigHold_r) && !finishCmd && !clrEntry && !trigEntry
         |=> $past(clrHold_r) == clrHold_r && $past(trigHold_r) == trigHold_r;
   endproperty
   a_finish_only: assert property (p_finish_only)
      else $error("Holdoff released without finish handshake");

   property p_readback;
      regRdEn && regAddr == `IHAC_OFS_PRIM_ADDR
         |=> regRdData_r[6:0] == $past(primAddr_r);
   endproperty
   a_readback: assert property (p_readback)
      else $error("Primary address readback wrong");

   property p_options_load;
      auxWr && ctlCode == `IHAC_CNT_OPTIONS |=> options_r == $past(comCode);
   endproperty
   a_options_load: assert property (p_options_load)
      else $error("Interface options not loaded");

   c_fast_byte:   cover property (srcSettled_r && useFast_r);
   c_unknown_cmd: cover property (unknownCmdFlag_r ##[1:20] validCmd);
   c_clear_hold:  cover property (clrHold_r ##[1:20] finishCmd);
   c_serial_poll_active_state_eoi:    cover property (spasActive && eoiAssert_r);

endmodule

`default_nettype wire

// ===== verif/ihac_bus_ctrl_model.sv
`default_nettype none

module ihac_bus_ctrl_model (
   // Clock
   input  wire logic       clk_sys,
   // Command byte toward the core
   output var  logic       cmdValid,
   output var  logic [7:0] cmdByte
);
   timeunit 1ns;
   timeprecision 100ps;

   initial begin
      cmdValid = 1'b0;
      cmdByte = 8'hFF;
   end

   // Released lines show the inverse, so a stale byte never matches
   task automatic sendCmd(input logic [7:0] b);
      @(posedge clk_sys);
      #1 cmdValid = 1'b1;
      cmdByte = b;
      @(posedge clk_sys);
      #1 cmdValid = 1'b0;
      cmdByte = ~b;
   endtask
endmodule

`default_nettype wire

// ===== verif/tb.sv
`include "ihac_regs.svh"
`default_nettype none

module tb
   import ihac_pkg::*;
;
   timeunit 1ns;
   timeprecision 100ps;

   localparam int SLOW = 8;
   localparam int FAST = 3;
   // Bits of the core state word driven by setCore
   localparam logic [5:0] TALK  = 6'h01;
   localparam logic [5:0] EOIQ  = 6'h02;
   localparam logic [5:0] POLL  = 6'h04;
   localparam logic [5:0] TRIG  = 6'h08;
   localparam logic [5:0] CLR   = 6'h10;
   localparam logic [5:0] SPOLL = 6'h20;

   logic       clk_sys = 1'b0;
   logic       rst;
   logic       regWrEn;
   logic       regRdEn;
   logic [4:0] regAddr;
   logic [7:0] regWrData;
   logic [7:0] regRdData_r;
   logic       spasActive;
   logic       dcasActive;
   logic       dtasActive;
   logic       pollResponse;
   logic       talkEoiReq;
   logic       cmdValid;
   logic [7:0] cmdByte;
   logic       srcTalkActive;
   logic       srcStart;
   logic       srcSettled_r;
   logic       eoiAssert_r;
   logic       driveOpenCollector_r;
   logic       dacHoldoff_r;
   logic       unknownCmdFlag_r;
   logic       talkAddrMatch_r;
   logic       listenAddrMatch_r;
   int         bad_count = 0;
   int         samples_checked = 0;

   ihac_ctl #(.SLOW_CYC(SLOW), .FAST_CYC(FAST)) dut_u (
      .clk_sys(clk_sys), .rst(rst), .regWrEn(regWrEn),
      .regRdEn(regRdEn), .regAddr(regAddr), .regWrData(regWrData),
      .regRdData_r(regRdData_r), .spasActive(spasActive),
      .dcasActive(dcasActive), .dtasActive(dtasActive),
      .pollResponse(pollResponse), .talkEoiReq(talkEoiReq),
      .cmdValid(cmdValid), .cmdByte(cmdByte),
      .srcTalkActive(srcTalkActive), .srcStart(srcStart),
      .srcSettled_r(srcSettled_r), .eoiAssert_r(eoiAssert_r),
      .driveOpenCollector_r(driveOpenCollector_r),
      .dacHoldoff_r(dacHoldoff_r), .unknownCmdFlag_r(unknownCmdFlag_r),
      .talkAddrMatch_r(talkAddrMatch_r),
      .listenAddrMatch_r(listenAddrMatch_r)
   );

   ihac_bus_ctrl_model ctrl_u (
      .clk_sys(clk_sys), .cmdValid(cmdValid), .cmdByte(cmdByte)
   );

   always #2.5 clk_sys = ~clk_sys;

   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         bad_count++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic close_out();
      $display("checks %0d, mismatches %0d", samples_checked, bad_count);
      if (bad_count == 0 && samples_checked > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask

   task automatic step(input int n);
      repeat (n) @(posedge clk_sys);
      #1;
   endtask

   task automatic setCore(input logic [5:0] v);
      {spasActive, dcasActive, dtasActive, pollResponse, talkEoiReq,
       srcTalkActive} = v;
   endtask

   task automatic wrReg(input logic [4:0] a, input logic [7:0] d);
      @(posedge clk_sys);
      #1 regWrEn = 1'b1;
      regAddr = a;
      regWrData = d;
      @(posedge clk_sys);
      #1 regWrEn = 1'b0;
      regWrData = ~d;
   endtask

   task automatic rdReg(input logic [4:0] a, output logic [7:0] d);
      @(posedge clk_sys);
      #1 regRdEn = 1'b1;
      regAddr = a;
      @(posedge clk_sys);
      #1 regRdEn = 1'b0;
      d = regRdData_r;
   endtask

   task automatic settle(output int n);
      @(posedge clk_sys);
      #1 srcStart = 1'b1;
      @(posedge clk_sys);
      #1 srcStart = 1'b0;
      n = 0;
      while (srcSettled_r !== 1'b1 && n < 1000) begin
         @(posedge clk_sys);
         #1 n++;
      end
   endtask

   task automatic t_src();
      int n;
      setCore(TALK);
      settle(n);
      check(16'(n), 16'(SLOW));
      settle(n);
      check(16'(n), 16'(SLOW));
      // First byte already sent, so fast applies at once
      wrReg(`IHAC_OFS_AUX_MODE, 8'hA4);
      settle(n);
      check(16'(n), 16'(FAST));
      settle(n);
      check(16'(n), 16'(FAST));
      setCore(6'h00);
      step(1);
      setCore(TALK);
      settle(n);
      check(16'(n), 16'(SLOW));
      wrReg(`IHAC_OFS_AUX_MODE, 8'hA0);
      settle(n);
      settle(n);
      check(16'(n), 16'(SLOW));
      // Mid-run reset must drop the fast option again
      wrReg(`IHAC_OFS_AUX_MODE, 8'hA4);
      settle(n);
      check(16'(n), 16'(FAST));
      rst = 1'b1;
      step(2);
      rst = 1'b0;
      settle(n);
      check(16'(n), 16'(SLOW));
      settle(n);
      check(16'(n), 16'(SLOW));
   endtask

   task automatic t_addr();
      logic [7:0] d;
      wrReg(`IHAC_OFS_PRIM_ADDR, 8'h05);
      // Write with select bit set is ignored and leaves the primary address
      wrReg(`IHAC_OFS_PRIM_ADDR, 8'h9F);
      wrReg(5'h1F, 8'h7F);
      rdReg(`IHAC_OFS_PRIM_ADDR, d);
      check(d & 8'h7F, 8'h05);
      rdReg(5'h1F, d);
      check(d, 8'h00);
      ctrl_u.sendCmd(8'h45);
      check({talkAddrMatch_r, listenAddrMatch_r}, 2'b10);
      ctrl_u.sendCmd(8'h25);
      check({talkAddrMatch_r, listenAddrMatch_r}, 2'b01);
      ctrl_u.sendCmd(8'h46);
      check({talkAddrMatch_r, listenAddrMatch_r}, 2'b00);
      wrReg(`IHAC_OFS_PRIM_ADDR, 8'h45);
      ctrl_u.sendCmd(8'h45);
      check({talkAddrMatch_r, listenAddrMatch_r}, 2'b00);
      ctrl_u.sendCmd(8'h25);
      check({talkAddrMatch_r, listenAddrMatch_r}, 2'b01);
      wrReg(`IHAC_OFS_PRIM_ADDR, 8'h25);
      rdReg(`IHAC_OFS_PRIM_ADDR, d);
      check(d & 8'h7F, 8'h25);
      ctrl_u.sendCmd(8'h25);
      check({talkAddrMatch_r, listenAddrMatch_r}, 2'b00);
      ctrl_u.sendCmd(8'h45);
      check({talkAddrMatch_r, listenAddrMatch_r}, 2'b10);
   endtask

   task automatic t_unknown();
      logic [7:0] d;
      ctrl_u.sendCmd(8'h03);
      check({unknownCmdFlag_r, dacHoldoff_r}, 2'b00);
      wrReg(`IHAC_OFS_AUX_MODE, 8'hA1);
      ctrl_u.sendCmd(8'h03);
      check({unknownCmdFlag_r, dacHoldoff_r}, 2'b11);
      rdReg(`IHAC_OFS_CAPTURE, d);
      check(d, 8'h03);
      step(4);
      check(dacHoldoff_r, 1'b1);
      wrReg(`IHAC_OFS_AUX_MODE, 8'h0F);
      step(1);
      check(dacHoldoff_r, 1'b0);
      ctrl_u.sendCmd(8'h14);
      check({unknownCmdFlag_r, dacHoldoff_r}, 2'b00);
      wrReg(`IHAC_OFS_AUX_MODE, 8'hA0);
   endtask

   task automatic t_hold();
      // Reserved command bits written as zero
      wrReg(`IHAC_OFS_AUX_MODE, 8'hC2);
      setCore(CLR);
      step(3);
      check(dacHoldoff_r, 1'b1);
      setCore(6'h00);
      wrReg(`IHAC_OFS_AUX_MODE, 8'h0F);
      step(3);
      check(dacHoldoff_r, 1'b1);
      wrReg(`IHAC_OFS_AUX_MODE, 8'h03);
      step(1);
      check(dacHoldoff_r, 1'b0);
      setCore(TRIG);
      step(3);
      check(dacHoldoff_r, 1'b0);
      setCore(6'h00);
      wrReg(`IHAC_OFS_AUX_MODE, 8'hC1);
      setCore(TRIG | CLR);
      step(3);
      check(dacHoldoff_r, 1'b1);
      wrReg(`IHAC_OFS_AUX_MODE, 8'h03);
      step(1);
      check(dacHoldoff_r, 1'b0);
      setCore(6'h00);
   endtask

   task automatic t_eoi();
      setCore(SPOLL | EOIQ);
      step(3);
      check(eoiAssert_r, 1'b0);
      wrReg(`IHAC_OFS_AUX_MODE, 8'hA2);
      setCore(SPOLL);
      step(3);
      check(eoiAssert_r, 1'b1);
      setCore(6'h00);
      step(3);
      check(eoiAssert_r, 1'b0);
      setCore(POLL);
      step(3);
      check(driveOpenCollector_r, 1'b1);
      setCore(6'h00);
      step(3);
      check(driveOpenCollector_r, 1'b0);
   endtask

   initial begin
      #50000;
      bad_count++;
      close_out();
   end

   initial begin
      rst = 1'b1;
      regWrEn = 1'b0;
      regRdEn = 1'b0;
      regAddr = 5'h00;
      regWrData = 8'h00;
      srcStart = 1'b0;
      setCore(6'h00);
      repeat (12) @(posedge clk_sys);
      #1 rst = 1'b0;
      check({eoiAssert_r, dacHoldoff_r}, 2'b00);
      check(driveOpenCollector_r, 1'b0);
      t_src();
      t_addr();
      t_unknown();
      t_hold();
      t_eoi();
      close_out();
   end
endmodule

`default_nettype wire
